// ---- logic/tmr8_consts.vh ----
// constants for the 8-bit timer/counter with two compare channels
`ifndef TMR8_CONSTS_VH
`define TMR8_CONSTS_VH
`define TMR8_BOTTOM 8'h00
`define TMR8_MAX 8'hff
`define TMR8_CNT_RST 8'h00
`define TMR8_OCR_RST 8'h00
`define TMR8_CS_STOP 3'h0
`define TMR8_WGM_NORMAL 3'h0
`define TMR8_WGM_PC_MAX 3'h1
`define TMR8_WGM_CTC 3'h2
`define TMR8_WGM_FAST_MAX 3'h3
`define TMR8_WGM_PC_OCR 3'h5
`define TMR8_WGM_FAST_OCR 3'h7
`define TMR8_COM_NONE 2'h0
`define TMR8_COM_TOGGLE 2'h1
`define TMR8_COM_CLEAR 2'h2
`define TMR8_COM_SET 2'h3
`define TMR8_DIV_W 10
`endif

// ---- logic/tmr8_tick_gen.v ----
// timer tick generator: one-cycle enable from the clock source select
`timescale 1ns/1ps
`include "tmr8_consts.vh"
module tmr8_tick_gen (
  // clock and reset
  input wire clk,
  input wire srst,
  // select and external event
  input wire [2:0] clock_source_select,
  input wire ext_event,
  // tick out
  output reg timer_tick
);
  reg [`TMR8_DIV_W-1:0] div_r;
  reg ext_d_r;
  always @(posedge clk) begin
    if (srst) begin
      div_r <= {`TMR8_DIV_W{1'b0}};
      // seeded from the pin so an idle-high input shows no false edge after reset
      ext_d_r <= ext_event;
      timer_tick <= 1'b0;
    end else begin
      div_r <= div_r + 1'b1;
      ext_d_r <= ext_event;
      case (clock_source_select)
        3'h0: timer_tick <= 1'b0;
        3'h1: timer_tick <= 1'b1;
        3'h2: timer_tick <= (div_r[2:0] == 3'h7);
        3'h3: timer_tick <= (div_r[5:0] == 6'h3f);
        3'h4: timer_tick <= (div_r[7:0] == 8'hff);
        3'h5: timer_tick <= (div_r == 10'h3ff);
        3'h6: timer_tick <= ext_d_r & ~ext_event;
        default: timer_tick <= ~ext_d_r & ext_event;
      endcase
    end
  end
endmodule

// ---- logic/tmr8_compare_unit.v ----
// one output compare channel: buffered compare value and output state
`timescale 1ns/1ps
`include "tmr8_consts.vh"
module tmr8_compare_unit (
  // clock and reset
  input wire clk,
  input wire srst,
  // counter context
  input wire [7:0] count,
  input wire timer_tick,
  input wire block_match,
  input wire pwm_mode,
  input wire update_point,
  input wire count_down,
  input wire bottom_tick,
  // software access
  input wire ocr_we,
  input wire [7:0] ocr_wdata,
  input wire force_strobe,
  input wire [1:0] compare_action_bits,
  // results
  output reg [7:0] compare_value,
  output reg [7:0] ocr_buffer,
  output wire match,
  output reg match_evt,
  output reg compare_output_state
);
  wire real_match;
  assign match = (count == compare_value);
  assign real_match = match & timer_tick & ~block_match;
  always @(posedge clk) begin
    if (srst) begin
      compare_value <= `TMR8_OCR_RST;
      ocr_buffer <= `TMR8_OCR_RST;
      match_evt <= 1'b0;
      compare_output_state <= 1'b0;
    end else begin
      match_evt <= real_match;
      if (ocr_we)
        ocr_buffer <= ocr_wdata;
      if (!pwm_mode) begin
        if (ocr_we)
          compare_value <= ocr_wdata;
      end else if (update_point) begin
        compare_value <= ocr_buffer;
      end
      // action bits read live, never buffered
      if (!pwm_mode && (real_match || force_strobe)) begin
        case (compare_action_bits)
          `TMR8_COM_NONE: compare_output_state <= compare_output_state;
          `TMR8_COM_TOGGLE: compare_output_state <= ~compare_output_state;
          `TMR8_COM_CLEAR: compare_output_state <= 1'b0;
          default: compare_output_state <= 1'b1;
        endcase
      // no mode-change term anywhere: the output state survives a mode switch
      end else if (pwm_mode && compare_action_bits[1]) begin
        if (real_match)
          compare_output_state <= compare_action_bits[0] ^ count_down;
        else if (bottom_tick)
          compare_output_state <= ~compare_action_bits[0];
      end
    end
  end
endmodule

// ---- logic/tmr8_timer.v ----
// 8-bit timer/counter top: counter, flags, two compare channels, pin override
`timescale 1ns/1ps
`include "tmr8_consts.vh"
module tmr8_timer (
  // clock and reset
  input wire clk,
  input wire srst,
  // configuration
  input wire [2:0] clock_source_select,
  input wire [2:0] waveform_mode_select,
  input wire [1:0] compare_action_bits_a,
  input wire [1:0] compare_action_bits_b,
  input wire ext_event,
  // count register access
  input wire cnt_we,
  input wire [7:0] cnt_wdata,
  output reg [7:0] count_register,
  // compare value access
  input wire ocr_a_we,
  input wire ocr_b_we,
  input wire [7:0] ocr_wdata,
  output reg [7:0] compare_value_a_rd,
  output reg [7:0] compare_value_b_rd,
  // force compare strobes
  input wire force_compare_strobe_a,
  input wire force_compare_strobe_b,
  // flags, enables, clearing
  input wire [2:0] int_enable,
  input wire [2:0] flag_clear_wr,
  input wire [2:0] int_ack,
  output reg compare_flag_a,
  output reg compare_flag_b,
  output reg overflow_flag,
  output reg [2:0] int_req,
  // pins
  input wire port_latch_a,
  input wire port_latch_b,
  input wire pin_direction_bit_a,
  input wire pin_direction_bit_b,
  output reg compare_output_a,
  output reg compare_output_a_oe,
  output reg compare_output_b,
  output reg compare_output_b_oe
);
  // every pwm code has bit0 set; clear-on-match and the unused codes stay non-pwm
  function is_pwm;
    input [2:0] wgm;
    begin
      is_pwm = wgm[0];
    end
  endfunction

  wire timer_tick;
  wire match_a;
  wire evt_a;
  wire evt_b;
  wire oc_a;
  wire oc_b;
  wire [7:0] cv_a;
  wire [7:0] cv_b;
  wire [7:0] buf_a;
  wire [7:0] buf_b;
  wire pwm_mode;
  wire phase_mode;
  wire top_is_ocr;
  wire [7:0] top_val;
  wire at_top;
  wire at_bottom;
  reg [7:0] cnt_nxt;
  reg down_r;
  reg down_nxt;
  reg block_r;
  reg ovf_set;
  reg upd_pt;

  assign pwm_mode = is_pwm(waveform_mode_select);
  assign phase_mode = (waveform_mode_select[1:0] == 2'h1);
  assign top_is_ocr = waveform_mode_select[2] | (waveform_mode_select == `TMR8_WGM_CTC);
  assign top_val = top_is_ocr ? cv_a : `TMR8_MAX;
  assign at_top = (count_register == top_val);
  assign at_bottom = (count_register == `TMR8_BOTTOM);

  tmr8_tick_gen u_tick (
    .clk(clk),
    .srst(srst),
    .clock_source_select(clock_source_select),
    .ext_event(ext_event),
    .timer_tick(timer_tick)
  );

  // next count and direction for one tick
  always @* begin
    cnt_nxt = count_register;
    down_nxt = down_r;
    ovf_set = 1'b0;
    upd_pt = 1'b0;
    if (phase_mode) begin
      if (at_top)
        down_nxt = 1'b1;
      else if (at_bottom)
        down_nxt = 1'b0;
      cnt_nxt = down_nxt ? count_register - 8'h01 : count_register + 8'h01;
      ovf_set = at_bottom;
      upd_pt = at_top;
    end else if (pwm_mode) begin
      down_nxt = 1'b0;
      cnt_nxt = at_top ? `TMR8_BOTTOM : count_register + 8'h01;
      ovf_set = at_top;
      upd_pt = at_top;
    end else if (waveform_mode_select == `TMR8_WGM_CTC) begin
      down_nxt = 1'b0;
      cnt_nxt = match_a ? `TMR8_BOTTOM : count_register + 8'h01;
      ovf_set = (count_register == `TMR8_MAX);
    end else begin
      // normal and reserved codes behave as a free-running up count
      down_nxt = 1'b0;
      cnt_nxt = count_register + 8'h01;
      ovf_set = (count_register == `TMR8_MAX);
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      count_register <= `TMR8_CNT_RST;
      down_r <= 1'b0;
      block_r <= 1'b0;
    end else begin
      if (cnt_we) begin
        count_register <= cnt_wdata;
        block_r <= 1'b1;
      end else if (timer_tick) begin
        count_register <= cnt_nxt;
        down_r <= down_nxt;
        block_r <= 1'b0;
      end
    end
  end

  tmr8_compare_unit u_cmp_a (
    .clk(clk),
    .srst(srst),
    .count(count_register),
    .timer_tick(timer_tick),
    .block_match(block_r),
    .pwm_mode(pwm_mode),
    .update_point(timer_tick & upd_pt & ~cnt_we),
    .count_down(down_r),
    .bottom_tick(timer_tick & ~phase_mode & at_top & ~cnt_we),
    .ocr_we(ocr_a_we),
    .ocr_wdata(ocr_wdata),
    .force_strobe(force_compare_strobe_a),
    .compare_action_bits(compare_action_bits_a),
    .compare_value(cv_a),
    .ocr_buffer(buf_a),
    .match(match_a),
    .match_evt(evt_a),
    .compare_output_state(oc_a)
  );

  tmr8_compare_unit u_cmp_b (
    .clk(clk),
    .srst(srst),
    .count(count_register),
    .timer_tick(timer_tick),
    .block_match(block_r),
    .pwm_mode(pwm_mode),
    .update_point(timer_tick & upd_pt & ~cnt_we),
    .count_down(down_r),
    .bottom_tick(timer_tick & ~phase_mode & at_top & ~cnt_we),
    .ocr_we(ocr_b_we),
    .ocr_wdata(ocr_wdata),
    .force_strobe(force_compare_strobe_b),
    .compare_action_bits(compare_action_bits_b),
    .compare_value(cv_b),
    .ocr_buffer(buf_b),
    .match(),
    .match_evt(evt_b),
    .compare_output_state(oc_b)
  );

  // flags: set wins over a clear in the same cycle
  always @(posedge clk) begin
    if (srst) begin
      compare_flag_a <= 1'b0;
      compare_flag_b <= 1'b0;
      overflow_flag <= 1'b0;
      int_req <= 3'h0;
    end else begin
      if (evt_a)
        compare_flag_a <= 1'b1;
      else if (flag_clear_wr[0] | int_ack[0])
        compare_flag_a <= 1'b0;
      if (evt_b)
        compare_flag_b <= 1'b1;
      else if (flag_clear_wr[1] | int_ack[1])
        compare_flag_b <= 1'b0;
      if (timer_tick & ~cnt_we & ovf_set)
        overflow_flag <= 1'b1;
      else if (flag_clear_wr[2] | int_ack[2])
        overflow_flag <= 1'b0;
      int_req <= int_enable & {overflow_flag, compare_flag_b, compare_flag_a};
    end
  end

  // pin override; direction always from the port bit
  always @(posedge clk) begin
    if (srst) begin
      compare_output_a <= 1'b0;
      compare_output_b <= 1'b0;
      compare_output_a_oe <= 1'b0;
      compare_output_b_oe <= 1'b0;
      compare_value_a_rd <= `TMR8_OCR_RST;
      compare_value_b_rd <= `TMR8_OCR_RST;
    end else begin
      compare_output_a <= (|compare_action_bits_a) ? oc_a : port_latch_a;
      compare_output_b <= (|compare_action_bits_b) ? oc_b : port_latch_b;
      compare_output_a_oe <= pin_direction_bit_a;
      compare_output_b_oe <= pin_direction_bit_b;
      compare_value_a_rd <= pwm_mode ? buf_a : cv_a;
      compare_value_b_rd <= pwm_mode ? buf_b : cv_b;
    end
  end
endmodule

// ---- test/tmr8_timer_assertions.sv ----
// port-level checker for the 8-bit timer top, bound below
`timescale 1ns/1ps
module tmr8_timer_chk (
  // clock and reset
  input wire clk,
  input wire srst,
  // configuration
  input wire [2:0] clock_source_select,
  input wire [2:0] waveform_mode_select,
  input wire [1:0] compare_action_bits_b,
  // count and compare access
  input wire cnt_we,
  input wire [7:0] cnt_wdata,
  input wire [7:0] count_register,
  input wire ocr_a_we,
  input wire [7:0] compare_value_a_rd,
  // flags and requests
  input wire [2:0] int_enable,
  input wire [2:0] flag_clear_wr,
  input wire [2:0] int_ack,
  input wire compare_flag_a,
  input wire compare_flag_b,
  input wire overflow_flag,
  input wire [2:0] int_req,
  // pin b
  input wire port_latch_b,
  input wire pin_direction_bit_b,
  input wire compare_output_b,
  input wire compare_output_b_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire stop = clock_source_select == 3'h0;
  wire run = clock_source_select == 3'h1;
  wire norm = waveform_mode_select == 3'h0;
  // the tick is registered, so a tick lands one edge after the select is seen
  stop_hold_a: assert property (stop ##1 stop && !cnt_we |=> $stable(count_register))
    else $error("count moved while stopped");
  write_wins_a: assert property (cnt_we |=> count_register == $past(cnt_wdata))
    else $error("count write not loaded");
  match_flag_a: assert property ($past(run) && $past(run, 2) && !$past(srst) && norm && $past(norm)
    && !cnt_we && !$past(cnt_we) && !$past(ocr_a_we) && count_register == compare_value_a_rd |-> ##2 compare_flag_a)
    else $error("compare flag a not set after match");
  match_block_a: assert property (cnt_we && run |-> ##3 !$rose(compare_flag_a))
    else $error("match not blocked after count write");
  wrap_ovf_a: assert property ($past(run) && !$past(srst) && norm && !cnt_we && count_register == 8'hff
    |=> overflow_flag && count_register == 8'h00)
    else $error("overflow wrap wrong");
  irq_gate_a: assert property (1'b1 |=> int_req == ($past(int_enable)
    & {$past(overflow_flag), $past(compare_flag_b), $past(compare_flag_a)}))
    else $error("interrupt request wrong");
  ovf_clear_a: assert property (flag_clear_wr[2] && norm && count_register != 8'hff |=> !overflow_flag)
    else $error("overflow flag not cleared");
  ack_clear_a: assert property (int_ack[1] && stop && $past(stop) && $past(stop, 2) |=> !compare_flag_b)
    else $error("compare flag b not cleared by service");
  port_src_a: assert property (compare_action_bits_b == 2'h0 |=> compare_output_b == $past(port_latch_b))
    else $error("pin b not from port latch");
  pin_dir_a: assert property (1'b1 |=> compare_output_b_oe == $past(pin_direction_bit_b))
    else $error("pin b direction wrong");
endmodule
bind tmr8_timer tmr8_timer_chk chk (.clk(clk), .srst(srst), .clock_source_select(clock_source_select),
  .waveform_mode_select(waveform_mode_select), .compare_action_bits_b(compare_action_bits_b), .cnt_we(cnt_we),
  .cnt_wdata(cnt_wdata), .count_register(count_register), .ocr_a_we(ocr_a_we),
  .compare_value_a_rd(compare_value_a_rd), .int_enable(int_enable), .flag_clear_wr(flag_clear_wr),
  .int_ack(int_ack), .compare_flag_a(compare_flag_a), .compare_flag_b(compare_flag_b),
  .overflow_flag(overflow_flag), .int_req(int_req), .port_latch_b(port_latch_b),
  .pin_direction_bit_b(pin_direction_bit_b), .compare_output_b(compare_output_b),
  .compare_output_b_oe(compare_output_b_oe));

// ---- test/test_tmr8_timer.sv ----
// self-checking bench for the 8-bit timer top
`timescale 1ns/1ps
module test_tmr8_timer;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg [2:0] cs = 3'h0, wgm = 3'h0, ien = 3'h0, fclr = 3'h0, ack = 3'h0;
  reg [1:0] act_a = 2'h0, act_b = 2'h0;
  reg ext = 1'b0, we = 1'b0, oa_we = 1'b0, ob_we = 1'b0, fs_a = 1'b0, fs_b = 1'b0;
  reg pl_a = 1'b0, pl_b = 1'b0, dir_a = 1'b0, dir_b = 1'b0;
  reg [7:0] wd = 8'h00, od = 8'h00;
  wire [7:0] cnt, rd_a, rd_b;
  wire [2:0] irq;
  wire fa, fb, ov, pa, pa_oe, pb, pb_oe;
  integer err_count = 0, checked = 0, i;
  initial forever #20 clk = ~clk;
  tmr8_timer uut (.clk(clk), .srst(srst), .clock_source_select(cs), .waveform_mode_select(wgm),
    .compare_action_bits_a(act_a), .compare_action_bits_b(act_b), .ext_event(ext), .cnt_we(we),
    .cnt_wdata(wd), .count_register(cnt), .ocr_a_we(oa_we), .ocr_b_we(ob_we), .ocr_wdata(od),
    .compare_value_a_rd(rd_a), .compare_value_b_rd(rd_b), .force_compare_strobe_a(fs_a),
    .force_compare_strobe_b(fs_b), .int_enable(ien), .flag_clear_wr(fclr), .int_ack(ack),
    .compare_flag_a(fa), .compare_flag_b(fb), .overflow_flag(ov), .int_req(irq), .port_latch_a(pl_a),
    .port_latch_b(pl_b), .pin_direction_bit_a(dir_a), .pin_direction_bit_b(dir_b), .compare_output_a(pa),
    .compare_output_a_oe(pa_oe), .compare_output_b(pb), .compare_output_b_oe(pb_oe));
  task wrap_up;
    begin
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [8*8:1] what, input [7:0] exp, input [7:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("wrong value %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // all stimulus changes at the falling edge
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task wr_cnt(input [7:0] v);
    begin wd = v; we = 1'b1; cyc(1); we = 1'b0; end
  endtask
  task force_a(input [1:0] code);
    begin act_a = code; fs_a = 1'b1; cyc(1); fs_a = 1'b0; cyc(2); end
  endtask
  task clr_flags(input [2:0] m);
    begin fclr = m; cyc(1); fclr = 3'h0; end
  endtask
  task wait_hi(input integer which);
    integer k;
    begin
      k = 0;
      while ((which == 0 ? fa : ov) !== 1'b1 && k < 600) begin cyc(1); k = k + 1; end
      if ((which == 0 ? fa : ov) !== 1'b1) begin
        err_count = err_count + 1;
        $display("wrong value flag wait expected 1 seen 0");
        wrap_up;
      end
    end
  endtask
  initial begin
    cyc(16);
    srst = 1'b0;
    act_a = 2'h1; dir_a = 1'b1; cyc(2);
    chk("pin a", 8'h00, pa);
    chk("pin a oe", 8'h01, pa_oe);
    $display("test reset done");
    wr_cnt(8'h5a); cyc(4);
    chk("count", 8'h5a, cnt);
    $display("test stopped write done");
    for (i = 0; i < 4; i = i + 1) begin
      force_a(i == 0 ? 2'h3 : i == 1 ? 2'h2 : 2'h1);
      chk("pin a", {7'h00, ~i[0]}, pa);
    end
    chk("flag a", 8'h00, fa);
    chk("count", 8'h5a, cnt);
    pl_a = 1'b1; force_a(2'h0);
    chk("pin a", 8'h01, pa);
    act_a = 2'h1; cyc(2);
    chk("pin a", 8'h00, pa);
    act_b = 2'h3; fs_b = 1'b1; cyc(1); fs_b = 1'b0; dir_b = 1'b1; cyc(2);
    chk("pin b", 8'h01, pb);
    act_b = 2'h0; cyc(2);
    chk("pin b", 8'h00, pb);
    $display("test force done");
    force_a(2'h3); wgm = 3'h3; force_a(2'h2);
    chk("pin a", 8'h01, pa);
    wgm = 3'h0; act_a = 2'h3; cyc(2);
    chk("pin a", 8'h01, pa);
    $display("test mode change done");
    od = 8'h20; oa_we = 1'b1; cyc(1); oa_we = 1'b0; cyc(2);
    chk("ocr a", 8'h20, rd_a);
    wgm = 3'h3; od = 8'h80; oa_we = 1'b1; cyc(1); oa_we = 1'b0; cyc(2);
    chk("ocr buf", 8'h80, rd_a);
    wgm = 3'h0; cyc(2);
    chk("ocr a", 8'h20, rd_a);
    act_a = 2'h2; wr_cnt(8'h1e); clr_flags(3'h7); cs = 3'h1;
    wait_hi(0);
    chk("count", 8'h22, cnt);
    cyc(2);
    chk("pin a", 8'h00, pa);
    cs = 3'h0; clr_flags(3'h1); wr_cnt(8'h20); cs = 3'h1; cyc(6);
    chk("flag a", 8'h00, fa);
    $display("test compare done");
    wr_cnt(8'h20);
    chk("count", 8'h20, cnt);
    cs = 3'h0; ien = 3'h4; wr_cnt(8'hfd); cs = 3'h1;
    wait_hi(1);
    chk("count", 8'h00, cnt);
    chk("flag a", 8'h00, fa);
    cs = 3'h0; cyc(1);
    chk("irq", 8'h04, {5'h00, irq});
    ack = 3'h4; cyc(1); ack = 3'h0;
    chk("ovf", 8'h00, ov);
    wr_cnt(8'hff); cs = 3'h1; wait_hi(1); cs = 3'h0; clr_flags(3'h3);
    chk("ovf", 8'h01, ov);
    clr_flags(3'h4);
    chk("ovf", 8'h00, ov);
    chk("flag b", 8'h01, fb);
    ack = 3'h2; cyc(1); ack = 3'h0;
    chk("flag b", 8'h00, fb);
    $display("test overflow done");
    wr_cnt(8'h10); cs = 3'h7; ext = 1'b1; cyc(3); ext = 1'b0; cyc(3);
    chk("count", 8'h11, cnt);
    $display("test external edge done");
    wrap_up;
  end
endmodule
